/* idws_pkg.sv */
package idws_pkg;

  // ****************************************
  // clock and link timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
  localparam int LINK_RATE_HZ = 400_000;
  // quarter of a link bit; the period is a least time, so it rounds up
  localparam int QTR_CYC = (CLK_HZ + 4 * LINK_RATE_HZ - 1) / (4 * LINK_RATE_HZ);
  localparam logic [4:0] QTR_LAST = 5'(QTR_CYC - 1);
  localparam int SPIKE_FAST_NS = 50;
  localparam int SPIKE_HS_NS = 10;
  localparam int SPIKE_FAST_CYC = (SPIKE_FAST_NS / CLK_PERIOD_NS < 1) ? 1 : SPIKE_FAST_NS / CLK_PERIOD_NS;
  localparam int SPIKE_HS_CYC = (SPIKE_HS_NS / CLK_PERIOD_NS < 1) ? 1 : SPIKE_HS_NS / CLK_PERIOD_NS;

  // ****************************************
  // byte framing and addressing
  // ****************************************
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] LAST_DATA_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  localparam logic [5:0] DEV_TYPE_CODE = 6'h2A; // value is arbitrary
  localparam logic [7:0] BCAST_ADDR = 8'h90;
  localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
  localparam logic [1:0] BYTE_ADDR = 2'h0;
  localparam logic [1:0] BYTE_HI = 2'h1;
  localparam logic [1:0] BYTE_LO = 2'h2;

  // ****************************************
  // conversion data
  // ****************************************
  localparam int CODE_W = 12;
  localparam int WORD_W = 14;
  localparam int FIFO_DEPTH = 16;
  localparam logic [CODE_W-1:0] CODE_RESET = 12'h000;
  localparam logic [1:0] PD_NORMAL = 2'h0;
  localparam logic [1:0] PD_1K = 2'h1;
  localparam logic [1:0] PD_100K = 2'h2;
  localparam logic [1:0] PD_OPEN = 2'h3;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_ADDR = 3'h1, D_DATA = 3'h3, D_ACK = 3'h2, D_SKIP = 3'h6
  } idws_dstate_type;

  typedef enum logic [1:0] {
    H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h3, H_STOP = 2'h2
  } idws_hstate_type;

  function automatic logic idws_addr_hit(input logic [7:0] b, input logic sel);
    logic reject;
    reject = (b == GEN_CALL_ADDR) || (b[7:3] == TEN_BIT_PREFIX);
    return !reject && ((b == BCAST_ADDR) || (b[7:2] == DEV_TYPE_CODE && b[1] == sel && !b[0]));
  endfunction : idws_addr_hit

  function automatic logic [7:0] idws_addr_byte(input logic sel, input logic bcast);
    return bcast ? BCAST_ADDR : {DEV_TYPE_CODE, sel, 1'b0};
  endfunction : idws_addr_byte

  function automatic logic [7:0] idws_hi_byte(input logic [WORD_W-1:0] w);
    return {2'h0, w[13:12], w[11:8]};
  endfunction : idws_hi_byte

endpackage : idws_pkg

/* idws_link_if.sv */
interface idws_link_if;
  logic scl_o;
  logic scl_oe;
  logic sda_h_o;
  logic sda_h_oe;
  logic sda_d_o;
  logic sda_d_oe;
  logic scl;
  logic sda;

  // open-drain wires with pull-ups: low while any enabled driver drives low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_h_oe & ~sda_h_o) | (sda_d_oe & ~sda_d_o));

  modport host (output scl_o, output scl_oe, output sda_h_o, output sda_h_oe, input scl, input sda);
  modport dev (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface : idws_link_if

/* idws_dev_end.sv */
// Behaviour
// - accept writes at all three bus rates; at the 25 MHz clk_sys a high-speed frame needs a faster clk_sys
// - never acknowledge ten-bit or general call
// - start condition begins address reception
// - first byte: seven address bits, direction
// - addressed slave pulls data low on ninth
// - nine clocks per byte, receiver acknowledges
// - master changes data only while clock low
// - master ends write with stop condition
// - match type code and select bit
// - select pin captured once at power-up
// - acknowledge only write direction matches
// - broadcast address acknowledged regardless of pin
// - register holds unsigned code, zero to full
// - inputs ignore narrow glitches
// - after address, shift in data bytes
// - upper byte: zeros, power-down bits, code
// - lower byte updates register after acknowledge
// - byte pairs repeat until stop or start
// - power-down bits select output mode
module idws_dev_end (
  idws_link_if.dev link,
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic address_select_pin,
  output logic [idws_pkg::CODE_W-1:0] dac_code,
  output logic power_down_select_high,
  output logic power_down_select_low,
  output logic [1:0] out_mode,
  output logic amp_enable,
  output logic update_pulse,
  output logic addressed
);
  import idws_pkg::*;

  // ****************************************
  // input synchronisers and glitch filter
  // ****************************************
  // chains are not reset so the select pin is valid when reset releases
  logic [2:0] scl_s_r;
  logic [2:0] sda_s_r;
  logic [2:0] asel_s_r;
  logic scl_f_r;
  logic sda_f_r;
  logic scl_p_r;
  logic sda_p_r;

  always_ff @(posedge clk_sys) begin
    scl_s_r <= {scl_s_r[1:0], link.scl};
    sda_s_r <= {sda_s_r[1:0], link.sda};
    asel_s_r <= {asel_s_r[1:0], address_select_pin};
  end

  // a level counts only once two later stages agree, so a pulse shorter
  // than one sample period never reaches the protocol logic
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      scl_f_r <= 1'b1;
      sda_f_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      if (scl_s_r[1] == scl_s_r[2]) begin
        scl_f_r <= scl_s_r[2];
      end
      if (sda_s_r[1] == sda_s_r[2]) begin
        sda_f_r <= sda_s_r[2];
      end
      scl_p_r <= scl_f_r;
      sda_p_r <= sda_f_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  // data may only move while the clock is low, so any data edge seen with
  // the clock high is a frame marker
  assign scl_rise = scl_f_r & ~scl_p_r;
  assign scl_fall = ~scl_f_r & scl_p_r;
  assign start_ev = scl_f_r & scl_p_r & sda_p_r & ~sda_f_r;
  assign stop_ev = scl_f_r & scl_p_r & ~sda_p_r & sda_f_r;

  // ****************************************
  // select pin strap
  // ****************************************
  logic asel_r;
  logic asel_done_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      asel_done_r <= 1'b0;
    end else begin
      asel_done_r <= 1'b1;
    end
  end

  // later changes on the pin are ignored until the next reset
  always_ff @(posedge clk_sys) begin
    if (!asel_done_r) begin
      asel_r <= asel_s_r[2];
    end
  end

  // ****************************************
  // protocol state machine
  // ****************************************
  idws_dstate_type st_r;
  logic [3:0] bit_cnt_r;
  logic [7:0] sh_r;
  logic [5:0] hi_hold_r;
  logic data_phase_r;
  logic lo_next_r;
  logic sda_pull_r;
  logic commit;

  assign commit = (st_r == D_ACK) && scl_fall && data_phase_r && lo_next_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= D_IDLE;
      bit_cnt_r <= BIT_CNT_ZERO;
      sh_r <= 8'h00;
      hi_hold_r <= 6'h00;
      data_phase_r <= 1'b0;
      lo_next_r <= 1'b0;
      sda_pull_r <= 1'b0;
    end else if (start_ev) begin
      // a repeated start also lands here and drops any half pair
      st_r <= D_ADDR;
      bit_cnt_r <= BIT_CNT_ZERO;
      data_phase_r <= 1'b0;
      lo_next_r <= 1'b0;
      sda_pull_r <= 1'b0;
    end else if (stop_ev) begin
      st_r <= D_IDLE;
      data_phase_r <= 1'b0;
      sda_pull_r <= 1'b0;
    end else begin
      case (st_r)
        D_ADDR, D_DATA: begin
          if (scl_rise && bit_cnt_r <= LAST_DATA_BIT) begin
            sh_r <= {sh_r[6:0], sda_f_r};
            bit_cnt_r <= bit_cnt_r + 4'h1;
          end else if (scl_fall && bit_cnt_r == ACK_BIT) begin
            if (st_r == D_DATA) begin
              st_r <= D_ACK;
              sda_pull_r <= 1'b1;
              if (!lo_next_r) begin
                hi_hold_r <= sh_r[5:0];
              end
            end else if (idws_addr_hit(sh_r, asel_r)) begin
              st_r <= D_ACK;
              sda_pull_r <= 1'b1;
            end else begin
              st_r <= D_SKIP;
            end
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            sda_pull_r <= 1'b0;
            st_r <= D_DATA;
            bit_cnt_r <= BIT_CNT_ZERO;
            if (data_phase_r) begin
              lo_next_r <= ~lo_next_r;
            end
            data_phase_r <= 1'b1;
          end
        end
        default: begin
          // idle and skip wait only for a start; the data line stays released
          sda_pull_r <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // conversion register
  // ****************************************
  // code is plain unsigned: the analog side divides it by the full-scale count
  logic [CODE_W-1:0] code_r;
  logic [1:0] pd_r;
  logic amp_en_r;
  logic upd_r;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      code_r <= CODE_RESET;
      pd_r <= PD_NORMAL;
    end else if (commit) begin
      code_r <= {hi_hold_r[3:0], sh_r};
      pd_r <= hi_hold_r[5:4];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      upd_r <= 1'b0;
      amp_en_r <= 1'b1;
    end else begin
      upd_r <= commit;
      amp_en_r <= (commit ? hi_hold_r[5:4] : pd_r) == PD_NORMAL;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // the rate is bounded by sampling: high-speed frames need a faster clk_sys
  assign link.sda_d_o = 1'b0;
  assign link.sda_d_oe = sda_pull_r;
  assign dac_code = code_r;
  assign power_down_select_high = pd_r[1];
  assign power_down_select_low = pd_r[0];
  assign out_mode = pd_r;
  assign amp_enable = amp_en_r;
  assign update_pulse = upd_r;
  assign addressed = data_phase_r;

endmodule : idws_dev_end

/* idws_host_end.sv */
module idws_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;

  assign out_valid = wp_r != rp_r;
  assign in_ready = !((wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]));
  assign out_data = mem[rp_r[AW-1:0]];

  always_ff @(posedge clk_sys) begin
    if (in_valid && in_ready) begin
      mem[wp_r[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_r <= wp_r + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule : idws_fifo

module idws_host_end (
  idws_link_if.host link,
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [idws_pkg::WORD_W-1:0] wr_word,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic target_sel,
  input wire logic broadcast,
  output logic busy,
  output logic nack_pulse,
  output logic done_pulse
);
  import idws_pkg::*;

  // ****************************************
  // word queue
  // ****************************************
  logic [WORD_W-1:0] q_data;
  logic q_valid;
  logic q_pop;

  idws_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_data(wr_word),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .out_data(q_data),
    .out_valid(q_valid),
    .out_ready(q_pop)
  );

  // ****************************************
  // data line sampling
  // ****************************************
  logic [2:0] sda_s_r;
  logic sda_f_r;

  always_ff @(posedge clk_sys) begin
    sda_s_r <= {sda_s_r[1:0], link.sda};
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sda_f_r <= 1'b1;
    end else if (sda_s_r[1] == sda_s_r[2]) begin
      sda_f_r <= sda_s_r[2];
    end
  end

  // ****************************************
  // quarter-bit divider
  // ****************************************
  idws_hstate_type st_r;
  logic [4:0] q_r;
  logic tick;

  assign tick = q_r == QTR_LAST;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || st_r == H_IDLE || tick) begin
      q_r <= 5'h00;
    end else begin
      q_r <= q_r + 5'h01;
    end
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  logic [1:0] ph_r;
  logic [1:0] byte_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic [WORD_W-1:0] word_r;
  logic ack_r;
  logic scl_pull_r;
  logic sda_pull_r;
  logic nack_r;
  logic done_r;
  logic pair_end;

  assign pair_end = st_r == H_BIT && tick && ph_r == 2'h3 && bit_r == ACK_BIT && ack_r && byte_r == BYTE_LO;
  // another queued word continues the frame without a stop
  assign q_pop = st_r == H_IDLE || pair_end;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_r <= H_IDLE;
      ph_r <= 2'h0;
      byte_r <= BYTE_ADDR;
      bit_r <= BIT_CNT_ZERO;
      tx_r <= 8'h00;
      word_r <= '0;
      ack_r <= 1'b0;
      scl_pull_r <= 1'b0;
      sda_pull_r <= 1'b0;
      nack_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      nack_r <= 1'b0;
      done_r <= 1'b0;
      case (st_r)
        H_IDLE: begin
          if (q_valid) begin
            word_r <= q_data;
            tx_r <= idws_addr_byte(target_sel, broadcast);
            byte_r <= BYTE_ADDR;
            bit_r <= BIT_CNT_ZERO;
            ph_r <= 2'h0;
            st_r <= H_START;
          end
        end
        H_START: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            if (ph_r == 2'h0) begin
              sda_pull_r <= 1'b1;
            end else begin
              scl_pull_r <= 1'b1;
              ph_r <= 2'h0;
              st_r <= H_BIT;
            end
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_pull_r <= (bit_r != ACK_BIT) && !tx_r[7];
              2'h1: scl_pull_r <= 1'b0;
              2'h2: begin
                if (bit_r == ACK_BIT) begin
                  ack_r <= !sda_f_r;
                end
              end
              default: begin
                scl_pull_r <= 1'b1;
                if (bit_r != ACK_BIT) begin
                  tx_r <= {tx_r[6:0], 1'b0};
                  bit_r <= bit_r + 4'h1;
                end else begin
                  bit_r <= BIT_CNT_ZERO;
                  if (!ack_r) begin
                    nack_r <= 1'b1;
                    st_r <= H_STOP;
                  end else if (byte_r == BYTE_ADDR) begin
                    tx_r <= idws_hi_byte(word_r);
                    byte_r <= BYTE_HI;
                  end else if (byte_r == BYTE_HI) begin
                    tx_r <= word_r[7:0];
                    byte_r <= BYTE_LO;
                  end else begin
                    done_r <= 1'b1;
                    if (q_valid) begin
                      word_r <= q_data;
                      tx_r <= idws_hi_byte(q_data);
                      byte_r <= BYTE_HI;
                    end else begin
                      st_r <= H_STOP;
                    end
                  end
                end
              end
            endcase
          end
        end
        default: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h0: sda_pull_r <= 1'b1;
              2'h1: scl_pull_r <= 1'b0;
              2'h2: sda_pull_r <= 1'b0;
              default: st_r <= H_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  assign link.scl_o = 1'b0;
  assign link.scl_oe = scl_pull_r;
  assign link.sda_h_o = 1'b0;
  assign link.sda_h_oe = sda_pull_r;
  assign busy = st_r != H_IDLE;
  assign nack_pulse = nack_r;
  assign done_pulse = done_r;

endmodule : idws_host_end

/* idws_checker.sv */
module idws_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic scl_oe,
  input wire logic sda_h_oe,
  input wire logic sda_d_oe,
  input wire logic scl,
  input wire logic sda
);
  // ****************************************
  // bit position on the wire
  // ****************************************
  logic scl_q_r;
  logic sda_q_r;
  logic ninth_sda_r;
  logic [3:0] cnt_r;
  logic hi;

  // hi skips the first cycle of each high phase, before cnt_r catches up
  assign hi = scl & scl_q_r;

  always_ff @(posedge clk_sys) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst || (hi && sda_q_r && !sda)) begin
      cnt_r <= 4'h0;
    end else if (scl && !scl_q_r) begin
      cnt_r <= (cnt_r == 4'h9) ? 4'h1 : cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (hi && cnt_r == 4'h9) begin
      ninth_sda_r <= sda;
    end
  end

  // ****************************************
  // wire rules
  // ****************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (sys_rst);

  chk_start_form: assert property ($rose(sda_h_oe) && scl |-> scl[*8] ##[1:20] !scl)
    else $error("start not followed by clock low");
  chk_stop_form: assert property ($fell(sda_h_oe) && scl |-> !scl_oe[*8])
    else $error("clock pulled after stop");
  chk_ninth_free: assert property (hi && cnt_r == 4'h9 |-> !sda_h_oe)
    else $error("host drives ninth bit");
  chk_ack_slot: assert property (sda_d_oe && hi |-> cnt_r == 4'h9)
    else $error("device drives outside ninth bit");
  chk_ack_steady: assert property ($fell(sda_d_oe) |-> !scl)
    else $error("ack released while clock high");
  chk_ack_release: assert property ($fell(scl) && cnt_r == 4'h9 && sda_d_oe |-> ##[1:12] !sda_d_oe)
    else $error("ack held too long");
  chk_nack_stop: assert property ($fell(scl) && cnt_r == 4'h9 && ninth_sda_r |->
    ##[1:40] (scl && sda_h_oe) ##[1:20] !sda_h_oe)
    else $error("no stop after nack");
  chk_high_time: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high too short");
  chk_low_time: assert property ($fell(scl) |-> !scl[*8])
    else $error("clock low too short");

  cover property (hi && cnt_r == 4'h9 && !sda);
  cover property (hi && cnt_r == 4'h9 && sda);
  cover property (hi && sda_q_r && !sda);
endmodule : idws_checker

/* i2c_dac_write_slave_tb.sv */
module i2c_dac_write_slave_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import idws_pkg::*;

  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic strap = 1'b0;
  logic [WORD_W-1:0] wr_word = 14'h0000;
  logic wr_valid = 1'b0;
  logic target_sel = 1'b0;
  logic broadcast = 1'b0;
  logic wr_ready, busy, nack_pulse, done_pulse, amp1, upd1, upd2, pdh1, pdl1, pdh2, pdl2, l1_scl, l1_sda, took;
  logic addressed2;
  logic [1:0] mode1;
  logic [CODE_W-1:0] code1, code2;
  logic [WORD_W-1:0] exp_q[$];
  logic [WORD_W-1:0] mon_w, w;
  logic [WORD_W-1:0] exp2 = 14'h0000;
  logic [WORD_W-1:0] tbl[5] = '{14'h0FFF, 14'h1000, 14'h2800, 14'h3001, 14'h05A5};
  logic [7:0] adr[6];
  logic [7:0] addr_seen;
  int errors = 0;
  int total_checks = 0;
  int nacks = 0, dones = 0, sent = 0, upd2_cnt = 0, bit_n = 9, n0;

  idws_link_if link1();
  idws_link_if link2();

  always #20 clk_sys = ~clk_sys;

  idws_host_end idws_host_end_inst (.link(link1), .clk_sys(clk_sys), .sys_rst(sys_rst), .wr_word(wr_word),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .target_sel(target_sel), .broadcast(broadcast), .busy(busy),
    .nack_pulse(nack_pulse), .done_pulse(done_pulse));
  idws_dev_end idws_dev_end_inst (.link(link1), .clk_sys(clk_sys), .sys_rst(sys_rst), .address_select_pin(strap),
    .dac_code(code1), .power_down_select_high(pdh1), .power_down_select_low(pdl1), .out_mode(mode1),
    .amp_enable(amp1), .update_pulse(upd1), .addressed());
  // second device, its bus driven by the bench so that faulty addresses can be sent
  idws_dev_end idws_dev_end_inst2 (.link(link2), .clk_sys(clk_sys), .sys_rst(sys_rst), .address_select_pin(1'b1),
    .dac_code(code2), .power_down_select_high(pdh2), .power_down_select_low(pdl2), .out_mode(),
    .amp_enable(), .update_pulse(upd2), .addressed(addressed2));
  idws_checker idws_checker_inst (.clk_sys(clk_sys), .sys_rst(sys_rst), .scl_oe(link1.scl_oe),
    .sda_h_oe(link1.sda_h_oe), .sda_d_oe(link1.sda_d_oe), .scl(link1.scl), .sda(link1.sda));

  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic print_verdict();
    if (errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  // offers a word only while ready, so a full buffer never sees a stale request
  task automatic send(input logic [WORD_W-1:0] v, input logic note);
    @(negedge clk_sys);
    took = (wr_ready === 1'b1);
    wr_word = v;
    wr_valid = took;
    if (took && note) begin
      exp_q.push_back(v);
      sent++;
    end
  endtask : send

  task automatic wait_idle();
    int n;
    @(negedge clk_sys);
    wr_valid = 1'b0;
    repeat (4) @(negedge clk_sys);
    check("busy", 16'(busy), 16'h0001);
    for (n = 0; n < 40000 && (busy !== 1'b0 || exp_q.size() > 0); n++) begin
      @(negedge clk_sys);
    end
    if (n == 40000) begin
      errors++;
      print_verdict();
    end
  endtask : wait_idle

  task automatic bb(input logic c, input logic d, input int n);
    link2.scl_oe = c;
    link2.sda_h_oe = d;
    repeat (n) @(negedge clk_sys);
  endtask : bb

  // ninth bit has long low phases: the device answers several cycles after each edge
  task automatic bb_byte(input logic [7:0] b, input logic exp);
    for (int i = 7; i >= 0; i--) begin
      bb(1'b1, !b[i], 2);
      bb(1'b0, !b[i], 4);
      bb(1'b1, !b[i], 2);
    end
    bb(1'b1, 1'b0, 5);
    // one-sample clock spike during the ack low phase must not end the ack
    bb(1'b0, 1'b0, 1);
    bb(1'b1, 1'b0, 6);
    bb(1'b0, 1'b0, 2);
    check("ack", 16'(!link2.sda), 16'(exp));
    bb(1'b0, 1'b0, 2);
    bb(1'b1, 1'b0, 12);
  endtask : bb_byte

  task automatic bb_frame(input logic [7:0] a, input logic exp, input logic [WORD_W-1:0] v, input int halves);
    bb(1'b1, 1'b0, 2);
    bb(1'b0, 1'b0, 4);
    bb(1'b0, 1'b1, 4);
    bb(1'b1, 1'b1, 2);
    bb_byte(a, exp);
    for (int i = 0; i < halves; i++) begin
      bb_byte(i[0] ? v[7:0] : {2'b00, v[13:8]}, exp);
    end
  endtask : bb_frame

  task automatic bb_stop();
    bb(1'b1, 1'b1, 2);
    bb(1'b0, 1'b1, 4);
    bb(1'b0, 1'b0, 12);
  endtask : bb_stop

  // ****************************************
  // result watcher
  // ****************************************
  always @(negedge clk_sys) begin
    if (upd1 === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare update", 16'h0001, 16'h0000);
      end else begin
        mon_w = exp_q.pop_front();
        check("code", 16'(code1), 16'(mon_w[11:0]));
        check("mode", 16'({pdh1, pdl1, mode1}), 16'({mon_w[13:12], mon_w[13:12]}));
        check("amp", 16'(amp1), 16'(mon_w[13:12] == PD_NORMAL));
      end
    end
    nacks += int'(nack_pulse === 1'b1);
    dones += int'(done_pulse === 1'b1);
    upd2_cnt += int'(upd2 === 1'b1);
    if (l1_scl && l1_sda && link1.scl && !link1.sda) begin
      bit_n = 0;
    end else if (link1.scl && !l1_scl && bit_n < 8) begin
      addr_seen = {addr_seen[6:0], link1.sda};
      bit_n++;
    end
    l1_scl = link1.scl;
    l1_sda = link1.sda;
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(32'h0e15));
    adr = '{8'h00, 8'hF0, {DEV_TYPE_CODE, 2'b11}, {DEV_TYPE_CODE, 2'b00}, BCAST_ADDR, {DEV_TYPE_CODE, 2'b10}};
    link2.scl_o = 1'b0;
    link2.sda_h_o = 1'b0;
    link2.scl_oe = 1'b0;
    link2.sda_h_oe = 1'b0;
    repeat (4) @(negedge clk_sys);
    sys_rst = 1'b0;
    check("code", 16'({pdh1, pdl1, code1}), 16'h0000);
    check("code b", 16'({pdh2, pdl2, code2}), 16'h0000);
    check("amp", 16'(amp1), 16'h0001);
    repeat (8) @(negedge clk_sys);
    strap = 1'b1;
    foreach (tbl[i]) begin
      send(tbl[i], 1'b1);
    end
    for (int i = 0; i < 40 && took; i++) begin
      send(14'($urandom), 1'b1);
    end
    check("full", 16'(took), 16'h0000);
    wait_idle();
    check("address", 16'(addr_seen), 16'({DEV_TYPE_CODE, 2'b00}));
    check("pairs", 16'(dones), 16'(sent));
    target_sel = 1'b1;
    send(14'h0123, 1'b0);
    wait_idle();
    check("nack", 16'(nacks), 16'h0001);
    broadcast = 1'b1;
    send(14'h1ABC, 1'b1);
    wait_idle();
    check("pairs", 16'(dones), 16'(sent));
    broadcast = 1'b0;
    for (int i = 0; i < 6; i++) begin
      w = 14'($urandom);
      n0 = upd2_cnt;
      bb_frame(adr[i], i > 3, w, 4);
      check("addressed", 16'(addressed2), 16'(i > 3));
      bb_stop();
      check("released", 16'(addressed2), 16'h0000);
      if (i > 3) begin
        exp2 = w;
      end
      check("updates", 16'(upd2_cnt - n0), (i > 3) ? 16'h0002 : 16'h0000);
      check("code b", 16'({pdh2, pdl2, code2}), 16'(exp2));
    end
    w = 14'($urandom);
    n0 = upd2_cnt;
    bb_frame(adr[5], 1'b1, ~w, 1);
    bb_frame(adr[5], 1'b1, w, 2);
    bb_stop();
    check("updates", 16'(upd2_cnt - n0), 16'h0001);
    check("code b", 16'({pdh2, pdl2, code2}), 16'(w));
    print_verdict();
  end
endmodule : i2c_dac_write_slave_tb
